// File: include/hcnc_pkg.sv
`default_nettype none
package hcnc_pkg;
  // ==========================================================
  // Sizes
  localparam int N_GLB = 16;
  localparam int N_REG = 32;
  localparam int N_QUAD = 4;
  localparam int N_LINE = 8;
  localparam int N_PIN = 16;
  localparam int N_PLL = 4;
  localparam int N_PO = 2;
  localparam int N_FAB = 8;
  localparam int N_ROW = 6;
  localparam int N_CLU = 3;
  localparam int N_IOC = 8;
  localparam int N_RES = 24;
  localparam int N_CFG = 64;
  localparam int AW = 12;
  // ==========================================================
  // Byte offsets
  localparam logic [AW-1:0] OFF_GLB = 12'h000;
  localparam logic [AW-1:0] OFF_REG = 12'h040;
  localparam logic [AW-1:0] OFF_PO = 12'h0c0;
  localparam logic [AW-1:0] OFF_ROW = 12'h0c8;
  localparam logic [AW-1:0] OFF_CLU = 12'h0d0;
  localparam logic [AW-1:0] OFF_IO = 12'h0e0;
  localparam logic [AW-1:0] OFF_GSTAT = 12'h100;
  localparam logic [AW-1:0] OFF_RSTAT = 12'h104;
  localparam logic [AW-1:0] OFF_MSTAT = 12'h108;
  // ==========================================================
  // Fields, masks, reset values
  localparam int F_SEL_A = 0;
  localparam int F_SEL_B = 8;
  localparam int F_DYN = 16;
  localparam int F_DUAL = 16;
  localparam int F_VERT = 17;
  localparam int F_USE = 8;
  localparam int F_PDN = 24;
  localparam int F_STRIDE = 8;
  localparam logic [31:0] M_GLB = 32'h0101_1f1f;
  localparam logic [31:0] M_REG = 32'h0103_001f;
  localparam logic [31:0] M_PO = 32'h0100_011f;
  localparam logic [31:0] M_SEL4 = 32'h1f1f_1f1f;
  localparam logic [31:0] M_CLU = 32'h0007_0707;
  localparam logic [31:0] RST_PDN = 32'h0100_0000;
  localparam logic [N_PIN-1:0] PIN_EXIST = 16'hf0ff;
  localparam logic [N_PIN-1:0] PIN_TB = 16'hf0ff;
  localparam logic [N_PIN-1:0] PIN_HZ = 16'h00ff;
  localparam logic [N_PIN-1:0] PIN_VT = 16'hf000;
  localparam logic [N_PLL-1:0] PLL_FAST = 4'h3;
  localparam logic [N_PLL-1:0] PLL_CORNER = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {WS_IDLE = 2'b01, WS_RESP = 2'b10} hcnc_wst_t;
  typedef struct packed {
    logic awvalid; logic [AW-1:0] awaddr;
    logic wvalid; logic [31:0] wdata; logic [3:0] wstrb; logic bready;
    logic arvalid; logic [AW-1:0] araddr; logic rready;
  } hcnc_axi_req_t;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } hcnc_axi_rsp_t;
  typedef struct packed {
    logic [N_PIN-1:0] pin_s1; logic [N_PIN-1:0] pin_s2;
    logic [2*N_PLL-1:0] pll_s1; logic [2*N_PLL-1:0] pll_s2;
    logic [N_GLB-1:0] gen; logic [N_GLB-1:0] gnet;
    logic [N_REG-1:0] ren; logic [N_REG-1:0] rnet;
    logic [N_PO-1:0] pen; logic [N_PO-1:0] pout;
    logic [N_ROW-1:0] row; logic [N_CLU-1:0] clu;
    logic [N_QUAD*N_IOC-1:0] ioc;
    logic [N_CFG-1:0][31:0] cfg;
    hcnc_axi_rsp_t rsp; hcnc_wst_t wst;
    logic aw_got; logic w_got; logic [AW-1:0] awaddr;
    logic [31:0] wdata; logic [3:0] wstrb;
  } hcnc_state_t;
endpackage : hcnc_pkg
`default_nettype wire

// File: hw/hcnc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Sixteen global, thirty-two regional networks, eight per quadrant
// - Each quadrant offers twenty-four clock resources
// - Twelve dedicated clock pins drive global or regional
// - Every network and PLL output has control
// - Fabric may drive global select dynamically
// - Dynamic select between any two pool sources
// - Static select may pick any mux input
// - Regional and PLL output selection static only
// - Regional sources: pins 15-12, 7-0, PLLs, logic
// - Only top/bottom pins feed regional selector
// - One source drives lines in adjacent quadrants
// - Dual direction limited by pin side, PLL type
// - Corner PLLs never drive dual-regional clocks
// - Cluster picks three of six row clocks
// - I/O region gets eight of twenty-four resources
// - Static power-down bit; unused networks powered down
// - Powered-down network shows no clock activity
// - Fabric enable applied synchronously per network
// - Enable acts on network only, PLL runs
// - PLL output pin muxes internal signal or clock
// - Dynamic selects only in user mode; static fixed
module hcnc_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire hcnc_pkg::hcnc_axi_req_t s_axi_req,
  output var hcnc_pkg::hcnc_axi_rsp_t s_axi_rsp,
  // Configuration state
  input wire logic user_mode,
  // Clock sources
  input wire logic [hcnc_pkg::N_PIN-1:0] dedicated_clock_input,
  input wire logic [hcnc_pkg::N_PLL-1:0] pll_counter_output_zero,
  input wire logic [hcnc_pkg::N_PLL-1:0] pll_counter_output_one,
  input wire logic [hcnc_pkg::N_FAB-1:0] fabric_route,
  // Fabric control
  input wire logic [hcnc_pkg::N_GLB-1:0] fabric_gsel,
  input wire logic [hcnc_pkg::N_GLB-1:0] fabric_gen,
  input wire logic [hcnc_pkg::N_REG-1:0] fabric_ren,
  input wire logic [hcnc_pkg::N_PO-1:0] fabric_pen,
  input wire logic [hcnc_pkg::N_PO-1:0] fabric_pio,
  // Networks
  output logic [hcnc_pkg::N_GLB-1:0] global_clock_net,
  output logic [hcnc_pkg::N_REG-1:0] regional_clock_net,
  output logic [hcnc_pkg::N_PO-1:0] pll_out_pin,
  output logic [hcnc_pkg::N_CLU-1:0] cluster_clock,
  output logic [hcnc_pkg::N_QUAD*hcnc_pkg::N_IOC-1:0] io_clock
);
  import hcnc_pkg::*;

  localparam int IG = int'(OFF_GLB >> 2);
  localparam int IR = int'(OFF_REG >> 2);
  localparam int IP = int'(OFF_PO >> 2);
  localparam int IW = int'(OFF_ROW >> 2);
  localparam int IC = int'(OFF_CLU >> 2);
  localparam int II = int'(OFF_IO >> 2);

  // ==========================================================
  // Decode helpers
  function automatic logic [31:0] wmask(input int i);
    if (i < IR) return M_GLB;
    if (i < IP) return M_REG;
    if (i < IW) return M_PO;
    if (i < IC) return M_SEL4;
    if (i == IC) return M_CLU;
    if (i < II) return 32'h0000_0000;
    return M_SEL4;
  endfunction : wmask

  function automatic logic [4:0] fld(input logic [31:0] w, input int k);
    return w[k*F_STRIDE +: 5];
  endfunction : fld

  function automatic logic pick24(input logic [N_RES-1:0] res, input logic [4:0] s);
    return (s < 5'(N_RES)) ? res[s] : 1'b0;
  endfunction : pick24

  // Pool: 0..15 pins, 16..23 PLL counters, 24..31 fabric routing
  function automatic logic reg_src_ok(input logic [4:0] s);
    return s[4] ? 1'b1 : PIN_TB[s[3:0]];
  endfunction : reg_src_ok

  function automatic logic dual_ok(input logic [4:0] s, input logic vert);
    logic [1:0] p;
    p = s[2:1];
    if (!s[4]) return vert ? PIN_VT[s[3:0]] : PIN_HZ[s[3:0]];
    if (s[3]) return 1'b1;
    if (PLL_CORNER[p]) return 1'b0;
    return vert ? PLL_FAST[p] : !PLL_FAST[p];
  endfunction : dual_ok

  function automatic hcnc_state_t rst_state();
    hcnc_state_t s;
    s = '0;
    for (int i = 0; i < IW; i++) begin
      s.cfg[i] = RST_PDN;
    end
    s.rsp.awready = 1'b1;
    s.rsp.wready = 1'b1;
    s.rsp.arready = 1'b1;
    s.wst = WS_IDLE;
    return s;
  endfunction : rst_state

  // ==========================================================
  // State
  hcnc_state_t st_r;
  hcnc_state_t st_nxt;
  logic [31:0] src;
  logic [N_GLB-1:0] graw;
  logic [N_GLB-1:0] gpdn;
  logic [N_GLB-1:0] gdyn;
  logic [N_REG-1:0] rraw;
  logic [N_REG-1:0] rpdn;
  logic [N_REG-1:0] rblock;
  logic [N_PO-1:0] puse;
  logic wr_fire;

  // ==========================================================
  // Next state
  always_comb begin
    logic [31:0] cw;
    logic [31:0] pw;
    logic [4:0] s;
    logic [4:0] pr;
    logic [N_RES-1:0] res;
    logic [31:0] merged;
    logic [31:0] m;
    int idx;
    cw = '0;
    pw = '0;
    s = '0;
    pr = '0;
    res = '0;
    merged = '0;
    m = '0;
    idx = 0;
    st_nxt = st_r;
    // Pins and PLL counters come from other clocks
    st_nxt.pin_s1 = dedicated_clock_input & PIN_EXIST;
    st_nxt.pin_s2 = st_r.pin_s1;
    for (int p = 0; p < N_PLL; p++) begin
      st_nxt.pll_s1[2*p] = pll_counter_output_zero[p];
      st_nxt.pll_s1[2*p+1] = pll_counter_output_one[p];
    end
    st_nxt.pll_s2 = st_r.pll_s1;
    src = {fabric_route, st_r.pll_s2, st_r.pin_s2};
    // Global networks
    for (int g = 0; g < N_GLB; g++) begin
      cw = st_r.cfg[IG+g];
      gdyn[g] = user_mode && cw[F_DYN] && fabric_gsel[g];
      s = gdyn[g] ? fld(cw, 1) : fld(cw, 0);
      graw[g] = src[s];
      gpdn[g] = cw[F_PDN];
      // Gate moves only while source is low: no runt pulses
      if (!graw[g]) begin
        st_nxt.gen[g] = !gpdn[g] && fabric_gen[g];
      end
      // Static power-down cuts at once; it only moves outside user mode
      st_nxt.gnet[g] = graw[g] && st_nxt.gen[g] && !gpdn[g];
    end
    // Regional networks, line r = quadrant*8 + line
    for (int r = 0; r < N_REG; r++) begin
      cw = st_r.cfg[IR+r];
      pr = 5'(r);
      if (cw[F_DUAL]) begin
        pr = pr ^ (cw[F_VERT] ? 5'h10 : 5'h08);
      end
      pw = st_r.cfg[IR+int'(pr)];
      s = fld(pw, 0);
      rblock[r] = !reg_src_ok(s) || (cw[F_DUAL] && !dual_ok(s, cw[F_VERT]));
      rraw[r] = src[s] && !rblock[r];
      rpdn[r] = cw[F_PDN];
      if (!rraw[r]) begin
        st_nxt.ren[r] = !rpdn[r] && fabric_ren[r];
      end
      st_nxt.rnet[r] = rraw[r] && st_nxt.ren[r] && !rpdn[r];
    end
    // PLL output pins; the PLL itself is never gated
    for (int j = 0; j < N_PO; j++) begin
      cw = st_r.cfg[IP+j];
      s = fld(cw, 0);
      puse[j] = cw[F_USE];
      if (!src[s]) begin
        st_nxt.pen[j] = !cw[F_PDN] && fabric_pen[j];
      end
      st_nxt.pout[j] = puse[j] ? (src[s] && st_nxt.pen[j]) : fabric_pio[j];
    end
    // Row clocks of quadrant 0 and one cluster
    res = {st_r.rnet[N_LINE-1:0], st_r.gnet};
    for (int k = 0; k < N_ROW; k++) begin
      st_nxt.row[k] = pick24(res, fld(st_r.cfg[IW + k/4], k%4));
    end
    for (int c = 0; c < N_CLU; c++) begin
      s = fld(st_r.cfg[IC], c);
      st_nxt.clu[c] = (s < 5'(N_ROW)) ? st_r.row[s[2:0]] : 1'b0;
    end
    // I/O clock regions, one per quadrant
    for (int q = 0; q < N_QUAD; q++) begin
      res = {st_r.rnet[q*N_LINE +: N_LINE], st_r.gnet};
      for (int k = 0; k < N_IOC; k++) begin
        s = fld(st_r.cfg[II + q*2 + k/4], k%4);
        st_nxt.ioc[q*N_IOC+k] = pick24(res, s);
      end
    end
    // ========================================================
    // Write channel
    if (s_axi_req.awvalid && st_r.rsp.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_req.awaddr;
      st_nxt.rsp.awready = 1'b0;
    end
    if (s_axi_req.wvalid && st_r.rsp.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_req.wdata;
      st_nxt.wstrb = s_axi_req.wstrb;
      st_nxt.rsp.wready = 1'b0;
    end
    wr_fire = 1'b0;
    case (st_r.wst)
      WS_IDLE: begin
        if (st_r.aw_got && st_r.w_got) begin
          idx = int'(st_r.awaddr[7:2]);
          // Static configuration is frozen in user mode
          wr_fire = (st_r.awaddr < OFF_GSTAT) && !user_mode;
          if (wr_fire) begin
            for (int b = 0; b < 4; b++) begin
              merged[b*8 +: 8] = st_r.wstrb[b] ? st_r.wdata[b*8 +: 8] : st_r.cfg[idx][b*8 +: 8];
            end
            m = wmask(idx);
            st_nxt.cfg[idx] = merged & m;
          end
          st_nxt.rsp.bresp = wr_fire ? RESP_OKAY : RESP_SLVERR;
          st_nxt.rsp.bvalid = 1'b1;
          st_nxt.wst = WS_RESP;
        end
      end
      WS_RESP: begin
        if (s_axi_req.bready) begin
          st_nxt.rsp.bvalid = 1'b0;
          st_nxt.aw_got = 1'b0;
          st_nxt.w_got = 1'b0;
          st_nxt.rsp.awready = 1'b1;
          st_nxt.rsp.wready = 1'b1;
          st_nxt.wst = WS_IDLE;
        end
      end
      default: begin
        st_nxt.wst = WS_IDLE;
      end
    endcase
    // ========================================================
    // Read channel
    if (st_r.rsp.rvalid && s_axi_req.rready) begin
      st_nxt.rsp.rvalid = 1'b0;
      st_nxt.rsp.arready = 1'b1;
    end
    if (s_axi_req.arvalid && st_r.rsp.arready) begin
      st_nxt.rsp.arready = 1'b0;
      st_nxt.rsp.rvalid = 1'b1;
      st_nxt.rsp.rresp = RESP_OKAY;
      if (s_axi_req.araddr < OFF_GSTAT) begin
        st_nxt.rsp.rdata = st_r.cfg[int'(s_axi_req.araddr[7:2])];
      end else if (s_axi_req.araddr[AW-1:2] == OFF_GSTAT[AW-1:2]) begin
        st_nxt.rsp.rdata = 32'(st_r.gnet);
      end else if (s_axi_req.araddr[AW-1:2] == OFF_RSTAT[AW-1:2]) begin
        st_nxt.rsp.rdata = st_r.rnet;
      end else if (s_axi_req.araddr[AW-1:2] == OFF_MSTAT[AW-1:2]) begin
        st_nxt.rsp.rdata = {23'h000000, user_mode, 3'h0, st_r.clu, st_r.pout};
      end else begin
        st_nxt.rsp.rdata = 32'h0000_0000;
        st_nxt.rsp.rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= rst_state();
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_rsp = st_r.rsp;
  assign global_clock_net = st_r.gnet;
  assign regional_clock_net = st_r.rnet;
  assign pll_out_pin = st_r.pout;
  assign cluster_clock = st_r.clu;
  assign io_clock = st_r.ioc;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_global_pdn_off: assert property (
    ##1 (st_r.gnet & $past(gpdn)) == '0
  ) else $error("powered-down global network toggled");

  a_regional_pdn_off: assert property (
    ##1 (st_r.rnet & $past(rpdn)) == '0
  ) else $error("powered-down regional network toggled");

  a_gate_on_low: assert property (
    ##1 ((st_r.gen ^ $past(st_r.gen)) & $past(graw)) == '0
  ) else $error("global gate changed while source high");

  a_dyn_sel_user: assert property (
    !user_mode |-> gdyn == '0
  ) else $error("dynamic select used outside user mode");

  a_cfg_frozen_user: assert property (
    (st_r.wst == WS_IDLE && st_r.aw_got && st_r.w_got && user_mode)
      |=> $stable(st_r.cfg) && st_r.rsp.bvalid && st_r.rsp.bresp == RESP_SLVERR
  ) else $error("configuration write accepted in user mode");

  a_dual_block: assert property (
    ##1 (st_r.rnet & $past(rblock)) == '0
  ) else $error("blocked dual-regional source reached network");

  a_pin_internal: assert property (
    !puse[0] |=> pll_out_pin[0] == $past(fabric_pio[0])
  ) else $error("PLL output pin ignored internal signal");

  a_enable_sync: assert property (
    (!fabric_gen[1] && !graw[1]) |=> !global_clock_net[1]
  ) else $error("disabled global network still active");

  a_bresp_hold: assert property (
    (st_r.rsp.bvalid && !s_axi_req.bready) |=> st_r.rsp.bvalid && $stable(st_r.rsp.bresp)
  ) else $error("write response dropped early");

  a_read_answer: assert property (
    (s_axi_req.arvalid && st_r.rsp.arready) |=> st_r.rsp.rvalid && !st_r.rsp.arready
  ) else $error("read not answered next cycle");

  a_reg_gate_low: assert property (
    ##1 ((st_r.ren ^ $past(st_r.ren)) & $past(rraw)) == '0
  ) else $error("regional gate changed while source high");

  a_pen_off: assert property (
    (puse[0] ##1 !st_r.pen[0]) |-> !pll_out_pin[0]
  ) else $error("disabled PLL output pin still active");

  a_row_pick: assert property (
    (st_r.cfg[IW][F_SEL_B +: 5] == 5'(N_GLB)) |=> st_r.row[1] == $past(st_r.rnet[0])
  ) else $error("row clock did not follow regional line");

  a_cluster_pick: assert property (
    (st_r.cfg[IC][F_SEL_B +: 5] == 5'h01) |=> cluster_clock[1] == $past(st_r.row[1])
  ) else $error("cluster clock did not follow row clock");

  a_io_pick: assert property (
    (st_r.cfg[II][F_SEL_A +: 5] == 5'h00) |=> io_clock[0] == $past(st_r.gnet[0])
  ) else $error("I/O clock did not follow global network");

  a_pin_mask: assert property (
    ((st_r.pin_s1 | st_r.pin_s2) & ~PIN_EXIST) == '0
  ) else $error("absent clock pin reached synchroniser");

  a_read_refuse: assert property (
    (s_axi_req.arvalid && st_r.rsp.arready && s_axi_req.araddr[AW-1:2] > OFF_MSTAT[AW-1:2])
      |=> st_r.rsp.rresp == RESP_SLVERR && st_r.rsp.rdata == '0
  ) else $error("unmapped read not refused");

endmodule : hcnc_top
`default_nettype wire

// File: test/hcnc_fabric.sv
`timescale 1ns/1ps
`default_nettype none
module hcnc_fabric (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Requests from bench
  input wire logic [15:0] gsel_req,
  input wire logic [15:0] gen_req,
  input wire logic [31:0] ren_req,
  input wire logic [1:0] pen_req,
  input wire logic [1:0] pio_req,
  // Sources
  output logic [15:0] pins,
  output logic [3:0] pll_zero,
  output logic [3:0] pll_one,
  output logic [7:0] route,
  // Controls
  output logic [15:0] gsel,
  output logic [15:0] gen,
  output logic [31:0] ren,
  output logic [1:0] pen,
  output logic [1:0] pio
);
  import hcnc_pkg::*;
  // ==========================================================
  // Source clocks
  logic [5:0] cnt_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 6'h00;
    end else begin
      cnt_r <= cnt_r + 6'h01;
    end
  end
  // Periods of 16, 32 and 64 cycles, slow against aclk
  assign pins = {16{cnt_r[3]}};
  assign pll_zero = {4{cnt_r[3]}};
  assign pll_one = {4{cnt_r[4]}};
  assign route = {8{cnt_r[5]}};
  // ==========================================================
  // Controls change on an edge and then hold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gsel <= 16'h0000;
      gen <= 16'h0000;
      ren <= 32'h0000_0000;
      pen <= 2'h0;
      pio <= 2'h0;
    end else begin
      gsel <= gsel_req;
      gen <= gen_req;
      ren <= ren_req;
      pen <= pen_req;
      pio <= pio_req;
    end
  end
endmodule : hcnc_fabric
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hcnc_pkg::*;
  // ==========================================================
  // Signals
  logic aclk;
  logic aresetn;
  logic user_mode;
  hcnc_axi_req_t req;
  hcnc_axi_rsp_t rsp;
  logic [15:0] pins;
  logic [3:0] pll_zero;
  logic [3:0] pll_one;
  logic [7:0] route;
  logic [15:0] gsel;
  logic [15:0] gen;
  logic [31:0] ren;
  logic [1:0] pen;
  logic [1:0] pio;
  logic [15:0] gsel_req;
  logic [15:0] gen_req;
  logic [31:0] ren_req;
  logic [1:0] pen_req;
  logic [1:0] pio_req;
  logic [15:0] gnet;
  logic [31:0] rnet;
  logic [1:0] pout;
  logic [2:0] clu;
  logic [31:0] ioc;
  int fail_count = 0;
  int comparisons = 0;
  // ==========================================================
  // Instances
  hcnc_fabric u_fabric (.aclk(aclk), .aresetn(aresetn), .gsel_req(gsel_req), .gen_req(gen_req),
    .ren_req(ren_req), .pen_req(pen_req), .pio_req(pio_req), .pins(pins), .pll_zero(pll_zero),
    .pll_one(pll_one), .route(route), .gsel(gsel), .gen(gen), .ren(ren), .pen(pen), .pio(pio));
  hcnc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_req(req), .s_axi_rsp(rsp), .user_mode(user_mode),
    .dedicated_clock_input(pins), .pll_counter_output_zero(pll_zero), .pll_counter_output_one(pll_one),
    .fabric_route(route), .fabric_gsel(gsel), .fabric_gen(gen), .fabric_ren(ren), .fabric_pen(pen),
    .fabric_pio(pio), .global_clock_net(gnet), .regional_clock_net(rnet), .pll_out_pin(pout),
    .cluster_clock(clu), .io_clock(ioc));
  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  function automatic logic pick(input int k, input int i);
    case (k)
      0: return gnet[i];
      1: return rnet[i];
      2: return pout[i];
      3: return clu[i];
      default: return ioc[i];
    endcase
  endfunction : pick
  // Long settle: gate waits for a low source phase, then pipeline stages
  task automatic expect_edges(input int k, input int i, input int want);
    int n;
    logic prev;
    logic cur;
    n = 0;
    repeat (80) @(posedge aclk);
    #1 prev = pick(k, i);
    repeat (64) begin
      @(posedge aclk);
      #1 cur = pick(k, i);
      if (prev === 1'b0 && cur === 1'b1) n++;
      prev = cur;
    end
    check(32'(n), 32'(want));
  endtask : expect_edges
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        req.bready <= 1'b0;
        check(32'(rsp.bresp), 32'(er));
        done = 1'b1;
      end
    end
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        req.rready <= 1'b0;
        check(rsp.rdata, ed);
        check(32'(rsp.rresp), 32'(er));
        done = 1'b1;
      end
    end
  endtask : rd
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rd(OFF_GLB + 12'h03c, RST_PDN, RESP_OKAY);
    rd(OFF_REG + 12'h07c, RST_PDN, RESP_OKAY);
    rd(OFF_PO + 12'h004, RST_PDN, RESP_OKAY);
    rd(OFF_GSTAT, 32'h0, RESP_OKAY);
    rd(12'h10c, 32'h0, RESP_SLVERR);
    wr(OFF_GSTAT, 32'h1, RESP_SLVERR);
    wr(OFF_GLB + 12'h03c, 32'hffff_ffff, RESP_OKAY);
    rd(OFF_GLB + 12'h03c, M_GLB, RESP_OKAY);
    wr(OFF_GLB + 12'h03c, RST_PDN, RESP_OKAY);
  endtask : t_reset
  task automatic t_global;
    int src[5] = '{0, 12, 16, 17, 24};
    int want[5] = '{4, 4, 4, 2, 1};
    for (int j = 0; j < 5; j++) begin
      wr(OFF_GLB + 12'h004, 32'(src[j]), RESP_OKAY);
      expect_edges(0, 1, want[j]);
    end
    wr(OFF_GLB + 12'h004, RST_PDN | 32'h11, RESP_OKAY);
    expect_edges(0, 1, 0);
  endtask : t_global
  task automatic t_dynamic;
    wr(OFF_GLB + 12'h008, 32'h0001_1100, RESP_OKAY);
    @(posedge aclk);
    user_mode <= 1'b1;
    gsel_req <= 16'h0004;
    expect_edges(0, 2, 2);
    @(posedge aclk);
    gsel_req <= 16'h0000;
    expect_edges(0, 2, 4);
    wr(OFF_GLB + 12'h008, 32'h0, RESP_SLVERR);
    rd(OFF_GLB + 12'h008, 32'h0001_1100, RESP_OKAY);
    wr(OFF_REG, 32'h0, RESP_SLVERR);
    @(posedge aclk);
    user_mode <= 1'b0;
    gsel_req <= 16'h0004;
    expect_edges(0, 2, 4);
    @(posedge aclk);
    gsel_req <= 16'h0000;
  endtask : t_dynamic
  task automatic t_enable;
    wr(OFF_GLB + 12'h004, 32'h11, RESP_OKAY);
    wr(OFF_GLB + 12'h00c, 32'h11, RESP_OKAY);
    @(posedge aclk);
    gen_req <= 16'hfffd;
    expect_edges(0, 1, 0);
    expect_edges(0, 3, 2);
    @(posedge aclk);
    gen_req <= 16'hffff;
    expect_edges(0, 1, 2);
  endtask : t_enable
  task automatic t_regional;
    int src[6] = '{12, 7, 8, 22, 18, 24};
    int w0[6] = '{4, 4, 0, 4, 4, 1};
    int w8[6] = '{0, 4, 0, 0, 0, 1};
    int w16[6] = '{4, 0, 0, 0, 4, 1};
    wr(OFF_REG + 12'h020, 32'h0001_0000, RESP_OKAY);
    wr(OFF_REG + 12'h040, 32'h0003_0000, RESP_OKAY);
    for (int j = 0; j < 6; j++) begin
      wr(OFF_REG, 32'(src[j]), RESP_OKAY);
      expect_edges(1, 0, w0[j]);
      expect_edges(1, 8, w8[j]);
      expect_edges(1, 16, w16[j]);
    end
  endtask : t_regional
  task automatic t_pll_out;
    wr(OFF_PO, 32'h0000_0110, RESP_OKAY);
    expect_edges(2, 0, 4);
    @(posedge aclk);
    pen_req <= 2'b10;
    expect_edges(2, 0, 0);
    wr(OFF_PO, 32'h0, RESP_OKAY);
    @(posedge aclk);
    pio_req <= 2'b01;
    repeat (8) @(posedge aclk);
    check(32'(pout), 32'h1);
    rd(OFF_MSTAT, 32'h0000_0001, RESP_OKAY);
  endtask : t_pll_out
  task automatic t_hier;
    wr(OFF_GLB, 32'h11, RESP_OKAY);
    wr(OFF_REG, 32'h0, RESP_OKAY);
    wr(OFF_ROW, 32'h0000_1000, RESP_OKAY);
    wr(OFF_CLU, 32'h0000_0100, RESP_OKAY);
    wr(OFF_IO, 32'h0000_1000, RESP_OKAY);
    expect_edges(3, 0, 2);
    expect_edges(3, 1, 4);
    expect_edges(4, 0, 2);
    expect_edges(4, 1, 4);
  endtask : t_hier
  // ==========================================================
  // Run
  task automatic stop_test;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Whole run is near 5400 cycles
  initial begin
    repeat (30000) @(posedge aclk);
    fail_count++;
    stop_test;
  end
  initial begin
    aresetn = 1'b0;
    user_mode = 1'b0;
    req = '0;
    gsel_req = 16'h0000;
    gen_req = 16'hffff;
    ren_req = 32'hffff_ffff;
    pen_req = 2'h3;
    pio_req = 2'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_global;
    t_dynamic;
    t_enable;
    t_regional;
    t_pll_out;
    t_hier;
    stop_test;
  end
endmodule : testbench
`default_nettype wire
